/* hdl/ufit_pkg.sv */
// Package for the frame interval timer: register map, fields, resets
// Assumes a 32-bit register port with word addresses as byte offsets
package ufit_pkg;
    localparam logic [7:0] UFIT_OFS_INTERVAL = 8'h34;
    localparam logic [7:0] UFIT_OFS_REMAIN = 8'h38;
    localparam int UFIT_TOGGLE_BIT = 31;
    localparam int UFIT_BUDGET_LSB = 16;
    localparam int UFIT_BUDGET_W = 15;
    localparam int UFIT_FI_W = 14;
    localparam logic [13:0] UFIT_FI_RESET = 14'h2edf;
    localparam logic [14:0] UFIT_BUDGET_RESET = 15'h0000;
    localparam logic [31:0] UFIT_RD_UNMAPPED = 32'h0000_0000;
    // Bit-time rate: full speed, 12 Mbit/s against a 10 MHz clock is
    // modelled by an external bit-time enable; divider ratio below is
    // not used anywhere in the design
    localparam logic [3:0] UFIT_BIT_DIV = 4'h1;
endpackage

/* hdl/ufit_count_if.sv */
// Interface between register file and the frame countdown core
// Assumes both ends run on the same clock
`timescale 1ns/1ns
interface ufit_count_if;
    logic [13:0] frame_interval;
    logic interval_toggle;
    logic run;
    logic start;
    logic bit_en;
    logic [13:0] frame_remaining;
    logic remaining_toggle;
    logic frame_start;
    modport regs (output frame_interval, output interval_toggle,
        output run, output start, output bit_en,
        input frame_remaining, input remaining_toggle, input frame_start);
    modport core (input frame_interval, input interval_toggle,
        input run, input start, input bit_en,
        output frame_remaining, output remaining_toggle,
        output frame_start);
endinterface

/* hdl/ufit_frame_core.sv */
// Frame remaining down counter and toggle copy
// Assumes bit_en is a one-cycle pulse per USB bit time
`timescale 1ns/1ns
module ufit_frame_core
    import ufit_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    ufit_count_if.core cif
);
    typedef struct packed {
        logic [13:0] rem;
        logic tog;
        logic sof;
    } ufit_core_t;
    ufit_core_t st;
    ufit_core_t next_st;

    // ****************************************
    // Countdown and reload
    // ****************************************
    always_comb
    begin
        next_st = st;
        next_st.sof = 1'b0;
        if (cif.start)
        begin
            next_st.rem = cif.frame_interval;
        end
        else if (cif.run && cif.bit_en)
        begin
            if (st.rem == '0)
            begin
                next_st.rem = cif.frame_interval;
                next_st.tog = cif.interval_toggle;
                next_st.sof = 1'b1;
            end
            else
            begin
                next_st.rem = st.rem - 14'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign cif.frame_remaining = st.rem;
    assign cif.remaining_toggle = st.tog;
    assign cif.frame_start = st.sof;

    property p_reload;
        @(posedge i_clk) disable iff (i_rst)
        (cif.run && cif.bit_en && !cif.start && st.rem == '0)
            |=> (st.rem == $past(cif.frame_interval) && st.sof);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload");
    property p_dec;
        @(posedge i_clk) disable iff (i_rst)
        (cif.run && cif.bit_en && !cif.start && st.rem != '0)
            |=> st.rem == $past(st.rem) - 14'h0001;
    endproperty
    a_dec: assert property (p_dec) else $error("no decrement");
    property p_tog;
        @(posedge i_clk) disable iff (i_rst)
        st.sof |-> st.tog == $past(cif.interval_toggle);
    endproperty
    a_tog: assert property (p_tog) else $error("toggle not copied");
    property p_start;
        @(posedge i_clk) disable iff (i_rst)
        cif.start |=> st.rem == $past(cif.frame_interval);
    endproperty
    a_start: assert property (p_start) else $error("no start load");
    property p_hold;
        @(posedge i_clk) disable iff (i_rst)
        (!cif.start && !cif.bit_en) |=> $stable(st.rem);
    endproperty
    a_hold: assert property (p_hold) else $error("moved off bit");
endmodule

/* hdl/ufit_top.sv */
// Frame interval timer: interval register, remaining counter, budget
// Assumes a simple synchronous register port and a bit-time enable
`timescale 1ns/1ns
module ufit_top
    import ufit_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_bit_en,
    input wire logic i_operational,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_xfer_start,
    input wire logic [14:0] i_xfer_bits,
    output logic [31:0] o_rdata,
    output logic o_sof,
    output logic o_xfer_ok,
    output logic [14:0] o_budget
);
    typedef struct packed {
        logic tog;
        logic [14:0] budget_cfg;
        logic [13:0] fi;
        logic [14:0] budget;
        logic op_d;
        logic [31:0] rdata;
    } ufit_top_t;
    ufit_top_t st;
    ufit_top_t next_st;
    ufit_count_if cif();

    // ****************************************
    // Countdown core
    // ****************************************
    ufit_frame_core u_core (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .cif(cif)
    );

    // Drive the core controls
    assign cif.frame_interval = st.fi;
    assign cif.interval_toggle = st.tog;
    assign cif.run = i_operational;
    assign cif.start = i_operational && !st.op_d;
    assign cif.bit_en = i_bit_en;

    // Transaction gate against the remaining budget
    assign o_xfer_ok = (i_xfer_bits <= st.budget);

    // ****************************************
    // Registers and budget counter
    // ****************************************
    always_comb
    begin
        next_st = st;
        next_st.op_d = i_operational;
        if (i_wr && i_addr == UFIT_OFS_INTERVAL)
        begin
            next_st.tog = i_wdata[UFIT_TOGGLE_BIT];
            next_st.budget_cfg = i_wdata[UFIT_BUDGET_LSB +: UFIT_BUDGET_W];
            next_st.fi = i_wdata[UFIT_FI_W-1:0];
        end
        // Budget reloads at frame start, else spends granted bits
        if (cif.frame_start)
        begin
            next_st.budget = st.budget_cfg;
        end
        else if (i_xfer_start && o_xfer_ok)
        begin
            next_st.budget = st.budget - i_xfer_bits;
        end
        next_st.rdata = st.rdata;
        if (i_rd)
        begin
            case (i_addr)
                UFIT_OFS_INTERVAL:
                    next_st.rdata = {st.tog, st.budget_cfg, 2'b00, st.fi};
                UFIT_OFS_REMAIN:
                    next_st.rdata = {cif.remaining_toggle, 17'h00000,
                        cif.frame_remaining};
                default:
                    next_st.rdata = UFIT_RD_UNMAPPED;
            endcase
        end
    end

    // State register with documented reset values
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st <= '0;
            st.fi <= UFIT_FI_RESET;
            st.budget_cfg <= UFIT_BUDGET_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_sof = cif.frame_start;
    assign o_budget = st.budget;

    property p_fi_reset;
        @(posedge i_clk) i_rst |=> st.fi == UFIT_FI_RESET;
    endproperty
    a_fi_reset: assert property (p_fi_reset) else $error("bad reset");
    property p_budget;
        @(posedge i_clk) disable iff (i_rst)
        cif.frame_start |=> st.budget == $past(st.budget_cfg);
    endproperty
    a_budget: assert property (p_budget) else $error("no budget");
    // A refused transaction must leave the budget untouched
    property p_gate;
        @(posedge i_clk) disable iff (i_rst)
        (i_xfer_start && !o_xfer_ok && !cif.frame_start)
            |=> o_budget == $past(o_budget);
    endproperty
    a_gate: assert property (p_gate) else $error("over budget");
endmodule

/* dv/usb_frame_interval_timer_bench.sv */
// Bench for the frame interval timer: registers, countdown, budget
// Assumes ufit_top with byte-offset register strobes and bit-time pulse
`timescale 1ns/1ns
module usb_frame_interval_timer_bench;
    import ufit_pkg::*;
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin \
n_mismatch++; $display("mismatch %s exp %h saw %h", nm, e, s); end end
    logic i_clk = 1'b0, i_rst = 1'b1, i_bit_en = 1'b0;
    logic i_operational = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic i_xfer_start = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, rv, cfg;
    logic [31:0] seed = 32'h79642b3c;
    logic [14:0] i_xfer_bits = 15'h0, o_budget, bud, xb;
    logic [13:0] fi;
    logic o_sof, o_xfer_ok;
    int n_mismatch = 0, total_checks = 0;
    // ***************************************
    // Clock, design and bench helpers
    // ***************************************
    always #50 i_clk = ~i_clk;
    ufit_top i_ufit_top (.i_clk(i_clk), .i_rst(i_rst),
        .i_bit_en(i_bit_en), .i_operational(i_operational),
        .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_xfer_start(i_xfer_start), .i_xfer_bits(i_xfer_bits),
        .o_rdata(o_rdata), .o_sof(o_sof), .o_xfer_ok(o_xfer_ok),
        .o_budget(o_budget));
    // Next pseudo-random word
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Stored image of an interval write, reserved bits dropped
    function automatic logic [31:0] stored(input logic [31:0] d);
        return d & 32'hffff3fff;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        rv = o_rdata;
    endtask
    // Send n bit-time pulses
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge i_clk);
            i_bit_en <= 1'b1;
            @(posedge i_clk);
            i_bit_en <= 1'b0;
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ***************************************
    // Main sequence
    // ***************************************
    initial
    begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(UFIT_OFS_INTERVAL);
        `CHK("interval reset", 32'h00002edf, rv)
        rd(UFIT_OFS_REMAIN);
        `CHK("remaining reset", 32'h0, rv)
        rd(8'h40);
        `CHK("unmapped", UFIT_RD_UNMAPPED, rv)
        $display("test reset done");
        // Toggle set, reserved bits set, short random interval
        seed = lfsr(seed);
        fi = 14'd4 + {12'h0, seed[1:0]};
        bud = {1'b0, seed[29:16]};
        cfg = {1'b1, bud, 2'b11, fi};
        wr(UFIT_OFS_INTERVAL, cfg);
        rd(UFIT_OFS_INTERVAL);
        `CHK("interval rw", stored(cfg), rv)
        wr(UFIT_OFS_REMAIN, lfsr(seed));
        rd(UFIT_OFS_REMAIN);
        `CHK("remaining ro", 32'h0, rv)
        $display("test regs done");
        @(posedge i_clk);
        i_operational <= 1'b1;
        rd(UFIT_OFS_REMAIN);
        `CHK("start load", {18'h0, fi}, rv)
        pulses(2);
        rd(UFIT_OFS_REMAIN);
        `CHK("decrement", {18'h0, fi - 14'd2}, rv)
        pulses(fi - 2);
        @(negedge i_clk);
        `CHK("no early sof", 1'b0, o_sof)
        pulses(1);
        for (int i = 0; i < 5 && o_sof !== 1'b1; i++)
            @(negedge i_clk);
        if (o_sof !== 1'b1)
        begin
            n_mismatch++;
            $display("mismatch sof wait exp 1 saw %b", o_sof);
            end_of_test();
        end
        @(negedge i_clk);
        `CHK("budget load", bud, o_budget)
        rd(UFIT_OFS_REMAIN);
        `CHK("reload toggle", {1'b1, 17'h0, fi}, rv)
        $display("test frame done");
        // Oversize, random fitting, then empty transaction
        for (int k = 0; k < 3; k++)
        begin
            seed = lfsr(seed);
            xb = (k == 0) ? bud + 15'd1 : (k == 1) ? seed[14:0] % bud : '0;
            @(posedge i_clk);
            i_xfer_bits <= xb;
            i_xfer_start <= 1'b1;
            @(negedge i_clk);
            `CHK("xfer ok", (xb <= bud), o_xfer_ok)
            if (xb <= bud)
                bud = bud - xb;
            @(posedge i_clk);
            i_xfer_start <= 1'b0;
            @(negedge i_clk);
            `CHK("budget left", bud, o_budget)
        end
        $display("test budget done");
        // Trim interval by one, toggle inverted
        cfg = {~cfg[31], cfg[30:14], fi + 14'd1};
        wr(UFIT_OFS_INTERVAL, cfg);
        rd(UFIT_OFS_INTERVAL);
        `CHK("interval trim", stored(cfg), rv)
        // Save interval, then reset in mid-run restores nominal interval
        rd(UFIT_OFS_INTERVAL);
        cfg = rv;
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(UFIT_OFS_INTERVAL);
        `CHK("interval rereset", 32'h00002edf, rv)
        wr(UFIT_OFS_INTERVAL, cfg);
        rd(UFIT_OFS_INTERVAL);
        `CHK("interval restore", cfg, rv)
        $display("test rereset done");
        end_of_test();
    end
endmodule
